// ===== bench/pin_source.sv
// model of the external signal sources that stand at the port pads
`timescale 1ns/1ps
module pin_source (
    input wire port_pin_pkg::pin_vec_type pin_out,
    input wire port_pin_pkg::pin_vec_type pin_oe,
    input wire port_pin_pkg::pin_vec_type ext_level,
    output port_pin_pkg::pin_vec_type pin_in
);
    import port_pin_pkg::*;
    // a pad the block drives shows its value, any other pad shows the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ===== bench/tb.sv
// self-checking bench for the pin port block
`timescale 1ns/1ps
`include "port_pin_map.svh"
module tb;
    import port_pin_pkg::*;
    logic clk, clk_en, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic stop_mode, wait_mode, debug_pin, wake_req, boot_mode_input, rc_osc_running;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, pwm_chan, pwm_en, port_irq;
    pin_vec_type pin_in, pin_out, pin_oe, ext_level;
    byte_type slew_control;
    int fails, samples_checked;
    port_pin_interrupt_filter port_pin_interrupt_filter_inst (.clk(clk), .clk_en(clk_en),
        .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .stop_mode(stop_mode),
        .wait_mode(wait_mode), .pwm_chan(pwm_chan), .pwm_en(pwm_en), .debug_pin(debug_pin),
        .port_irq(port_irq), .wake_req(wake_req), .slew_control(slew_control),
        .boot_mode_input(boot_mode_input), .rc_osc_running(rc_osc_running));
    pin_source pin_source_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));
    // bus clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer: setup, then access until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) begin
            fails++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 8'h00);
        chk(name, exp, rd);
    endtask
    function automatic logic [11:0] ra(input logic [1:0] p, input logic [2:0] o);
        return {5'h00, p, 5'h00} + {7'h00, o, 2'b00};
    endfunction
    // bounded wait for a request pattern, then compare it
    task automatic wait_irq(input logic [3:0] exp);
        int n;
        for (n = 0; n < 200 && port_irq !== exp; n++) @(posedge clk);
        chk("port_irq", {28'h0000000, exp}, {28'h0000000, port_irq});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_drive();
        wr(ra(0, `PP_OFS_DATA), 8'hA5);
        wr(ra(0, `PP_OFS_DIR), 8'hFF);
        cyc(2);
        chk("pin_out", 32'hA5, {24'h0, pin_out[7:0]});
        chk("pin_oe", 32'hFF, {24'h0, pin_oe[7:0]});
        rdc("data out", ra(0, `PP_OFS_DATA), 32'hA5);
        wr(ra(0, `PP_OFS_OPEN_DRAIN), 8'hFF);
        cyc(2);
        chk("pin_oe od", 32'h5A, {24'h0, pin_oe[7:0]});
        wr(ra(0, `PP_OFS_DIR), 8'h00);
        ext_level[7:0] <= 8'h3C;
        cyc(4);
        rdc("data in", ra(0, `PP_OFS_DATA), 32'h3C);
        wr(ra(0, `PP_OFS_OPEN_DRAIN), 8'h00);
        $display("test drive done");
    endtask
    // glitch, valid falling edge, clear by writing one, masked pin
    task automatic t_filter();
        wait_mode <= 1'b1;
        wr(ra(1, `PP_OFS_POLARITY), 8'h00);
        wr(ra(1, `PP_OFS_MASK), 8'h01);
        wr(ra(1, `PP_OFS_FLAG), 8'hFF);
        ext_level[8] <= 1'b0;
        cyc(3);
        ext_level[8] <= 1'b1;
        cyc(12);
        rdc("flag glitch", ra(1, `PP_OFS_FLAG), 32'h00);
        ext_level[8] <= 1'b0;
        wait_irq(4'b0010);
        rdc("flag edge", ra(1, `PP_OFS_FLAG), 32'h01);
        chk("wake_req", 32'h1, {31'h0, wake_req});
        wr(ra(1, `PP_OFS_FLAG), 8'h00);
        rdc("flag kept", ra(1, `PP_OFS_FLAG), 32'h01);
        wr(ra(1, `PP_OFS_FLAG), 8'h01);
        rdc("flag cleared", ra(1, `PP_OFS_FLAG), 32'h00);
        wait_irq(4'b0000);
        wr(ra(1, `PP_OFS_MASK), 8'h00);
        ext_level[10:9] <= 2'h0;
        cyc(12);
        rdc("flag masked", ra(1, `PP_OFS_FLAG), 32'h06);
        chk("port_irq masked", 32'h0, {28'h0, port_irq});
        wr(ra(1, `PP_OFS_FLAG), 8'hFF);
        wait_mode <= 1'b0;
        $display("test filter done");
    endtask
    // rising polarity on a pin the block itself drives
    task automatic t_rise_out();
        wr(ra(2, `PP_OFS_POLARITY), 8'h01);
        wr(ra(2, `PP_OFS_MASK), 8'h01);
        wr(ra(2, `PP_OFS_DATA), 8'h00);
        wr(ra(2, `PP_OFS_DIR), 8'h01);
        cyc(8);
        wr(ra(2, `PP_OFS_FLAG), 8'hFF);
        wr(ra(2, `PP_OFS_DATA), 8'h01);
        wait_irq(4'b0100);
        wr(ra(2, `PP_OFS_FLAG), 8'hFF);
        wr(ra(2, `PP_OFS_DATA), 8'h00);
        cyc(12);
        rdc("flag falling", ra(2, `PP_OFS_FLAG), 32'h00);
        wr(ra(2, `PP_OFS_MASK), 8'h00);
        wr(ra(2, `PP_OFS_DIR), 8'h00);
        $display("test rise_out done");
    endtask
    // stop mode: local sampling oscillator, wake, slew forced off
    task automatic t_stop();
        int n;
        wr(`PP_ADDR_SLEW, 8'h5A);
        cyc(2);
        chk("slew_control", 32'h5A, {24'h0, slew_control});
        ext_level[7:0] <= 8'hFF;
        wr(ra(0, `PP_OFS_POLARITY), 8'h00);
        cyc(12);
        wr(ra(0, `PP_OFS_FLAG), 8'hFF);
        wr(ra(0, `PP_OFS_MASK), 8'h02);
        chk("rc run mode", 32'h0, {31'h0, rc_osc_running});
        stop_mode <= 1'b1;
        cyc(3);
        chk("slew stop", 32'h0, {24'h0, slew_control});
        ext_level[1] <= 1'b0;
        for (n = 0; n < 20 && rc_osc_running !== 1'b1; n++) @(posedge clk);
        chk("rc demand", 32'h1, {31'h0, rc_osc_running});
        wait_irq(4'b0001);
        chk("wake stop", 32'h1, {31'h0, wake_req});
        cyc(6);
        chk("rc idle", 32'h0, {31'h0, rc_osc_running});
        stop_mode <= 1'b0;
        wr(ra(0, `PP_OFS_MASK), 8'h00);
        cyc(2);
        chk("slew run", 32'h5A, {24'h0, slew_control});
        $display("test stop done");
    endtask
    // pwm channel routing and an unmapped access
    task automatic t_route();
        pwm_en <= 4'h1;
        pwm_chan <= 4'h1;
        wr(`PP_ADDR_ROUTE, 8'h00);
        cyc(3);
        chk("pwm pin 8", 32'h3, {30'h0, pin_oe[8], pin_out[8]});
        wr(`PP_ADDR_ROUTE, 8'h01);
        cyc(3);
        chk("pwm pin 16", 32'h3, {29'h0, pin_oe[8], pin_oe[16], pin_out[16]});
        rdc("route", `PP_ADDR_ROUTE, 32'h1);
        clk_en <= 1'b0;
        pwm_chan <= 4'h0;
        cyc(3);
        chk("frozen pin 16", 32'h1, {31'h0, pin_out[16]});
        clk_en <= 1'b1;
        pwm_en <= 4'h0;
        apb(12'h0FC, 1'b0, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test route done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        samples_checked = 0;
        {psel, penable, pwrite, stop_mode, wait_mode} = 5'h00;
        {sys_rst, clk_en, debug_pin} = 3'h7;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        {pwm_chan, pwm_en} = 8'h00;
        ext_level = 32'hFFFFFFFF;
        cyc(5);
        sys_rst <= 1'b0;
        cyc(1);
        chk("boot mode", 32'h1, {31'h0, boot_mode_input});
        rdc("mode reg", `PP_ADDR_MODE, 32'h1);
        $display("test reset done");
        t_drive();
        t_filter();
        t_rise_out();
        t_stop();
        t_route();
        stop_test();
    end
endmodule

// ===== hw/pin_edge_filter.sv
// per-pin sampling glitch filter and edge detector
`timescale 1ns/1ps
`include "port_pin_map.svh"
module pin_edge_filter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic sample_en,
    input wire logic pin_level,
    input wire logic edge_rising,
    output logic valid_edge,
    output logic settling
);
    import port_pin_pkg::*;

    logic [2:0] run_cnt_q;
    logic [2:0] run_cnt_d;
    logic last_q;
    logic active_lvl;
    filt_state_type state_q;
    filt_state_type state_d;

    // count consecutive equal samples, saturating
    assign active_lvl = (pin_level == edge_rising);
    assign run_cnt_d = (pin_level != last_q) ? 3'h1 :
        ((run_cnt_q == `PP_FILTER_SAT) ? run_cnt_q : run_cnt_q + 3'h1);
    // an unsampled level change restarts the run, so it wakes the stop oscillator too
    assign settling = (run_cnt_q <= `PP_FILTER_RUN) || (pin_level != last_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_cnt_q <= 3'h0;
            last_q <= 1'b0;
        end else if (clk_en && sample_en) begin
            run_cnt_q <= run_cnt_d;
            last_q <= pin_level;
        end
    end

    // arm on an inactive run, fire on a later active run
    always_comb begin
        state_d = state_q;
        case (state_q)
            FILT_WAIT_IDLE: begin
                if (!active_lvl && run_cnt_d >= `PP_FILTER_RUN) begin
                    state_d = FILT_ARMED;
                end
            end
            FILT_ARMED: begin
                if (active_lvl && run_cnt_d == `PP_FILTER_RUN) begin
                    state_d = FILT_WAIT_IDLE;
                end
            end
            default: state_d = FILT_WAIT_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= FILT_WAIT_IDLE;
        end else if (clk_en && sample_en) begin
            state_q <= state_d;
        end
    end

    assign valid_edge = clk_en && sample_en && state_q == FILT_ARMED && active_lvl &&
        run_cnt_d == `PP_FILTER_RUN;

    // an edge seen under steady sampling needs four equal samples
    a_edge_after_run: assert property (
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sample_en)[*4] ##0 valid_edge |->
            ($past(pin_level, 1) == pin_level && $past(pin_level, 2) == pin_level &&
            $past(pin_level, 3) == pin_level))
        else $error("edge accepted after a short pulse");
endmodule

// ===== hw/port_pin_interrupt_filter.sv
// pin port with open-drain, routing, slew control and filtered pin interrupts
// Operation
// - open-drain select releases the high drive
// - mask bit gates each pin flag into its port request
// - filtered edge sets a sticky pin flag
// - four ports, per-pin enable and edge choice
// - one shared request line per port
// - detection works in input or output direction
// - request when flag and enable both set
// - pending enabled interrupt wakes from stop, wait
// - pulses of three clocks rejected, four accepted
// - four inactive then four active samples
// - run and wait sample every bus clock
// - stop mode samples on local oscillator
// - oscillator runs only while a pin settles
// - route register moves pwm channels to alternates
// - debug pin gives boot mode during reset
// - slew bits steer motor pad slew limiting
// - data read returns pin or output by direction
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "port_pin_map.svh"
module port_pin_interrupt_filter (
    input wire logic clk,
    input wire logic clk_en,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire port_pin_pkg::pin_vec_type pin_in,
    output port_pin_pkg::pin_vec_type pin_out,
    output port_pin_pkg::pin_vec_type pin_oe,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic [3:0] pwm_chan,
    input wire logic [3:0] pwm_en,
    input wire logic debug_pin,
    output logic [3:0] port_irq,
    output logic wake_req,
    output port_pin_pkg::byte_type slew_control,
    output logic boot_mode_input,
    output logic rc_osc_running
);
    import port_pin_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers and internal signals

    logic [3:0][7:0] port_output_value_q;
    logic [3:0][7:0] direction_bits_q;
    logic [3:0][7:0] open_drain_select_q;
    logic [3:0][7:0] pull_polarity_select_q;
    logic [3:0][7:0] pin_irq_mask_q;
    logic [3:0][7:0] pin_irq_flag_q;
    logic [7:0] slew_q;
    logic [3:0] alt_route_select_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    pin_vec_type pin_meta_q;
    pin_vec_type pin_sync_q;
    logic dbg_meta_q;
    logic dbg_sync_q;
    pin_vec_type valid_edge;
    pin_vec_type settling;
    pin_vec_type flag_clr;
    pin_vec_type periph_own;
    pin_vec_type periph_val;
    pin_vec_type out_val;
    pin_vec_type drive_en;
    logic [3:0] irq_d;
    logic [1:0] port_sel;
    logic [2:0] reg_sel;
    logic is_global;
    logic addr_ok;
    logic wr_en;
    logic setup;
    logic osc_run;
    logic rc_tick;
    logic sample_en;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign port_sel = paddr[6:5];
    assign reg_sel = paddr[4:2];
    assign is_global = paddr[7];
    assign setup = psel && !penable;
    assign wr_en = clk_en && psel && penable && pwrite && addr_ok;

    // valid addresses: port windows with registers 0..6 and three globals
    always_comb begin
        addr_ok = 1'b0;
        if (paddr[11:8] == 4'h0 && paddr[1:0] == 2'h0) begin
            if (!is_global) begin
                addr_ok = (reg_sel <= `PP_OFS_FLAG);
            end else begin
                addr_ok = (paddr == `PP_ADDR_SLEW) || (paddr == `PP_ADDR_ROUTE) ||
                    (paddr == `PP_ADDR_MODE);
            end
        end
    end

    // slave answers in the first access cycle while the clock is enabled
    assign pready = clk_en;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta_q <= 32'h00000000;
            pin_sync_q <= 32'h00000000;
        end else if (clk_en) begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // debug pin keeps sampling during reset so the strap can be caught
    always_ff @(posedge clk) begin
        if (clk_en) begin
            dbg_meta_q <= debug_pin;
            dbg_sync_q <= dbg_meta_q;
        end
    end

    // boot mode follows the pin while reset is held, then stays latched
    always_ff @(posedge clk) begin
        if (clk_en && sys_rst) begin
            boot_mode_input <= dbg_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    // software written port registers, low byte lane only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_output_value_q <= '0;
            direction_bits_q <= '0;
            open_drain_select_q <= '0;
            pull_polarity_select_q <= '0;
            pin_irq_mask_q <= '0;
            slew_q <= `PP_RST_BYTE;
            alt_route_select_q <= `PP_RST_ROUTE;
        end else if (wr_en && pstrb[0]) begin
            if (!is_global) begin
                case (reg_sel)
                    `PP_OFS_DATA: port_output_value_q[port_sel] <= pwdata[7:0];
                    `PP_OFS_DIR: direction_bits_q[port_sel] <= pwdata[7:0];
                    `PP_OFS_OPEN_DRAIN: open_drain_select_q[port_sel] <= pwdata[7:0];
                    `PP_OFS_POLARITY: pull_polarity_select_q[port_sel] <= pwdata[7:0];
                    `PP_OFS_MASK: pin_irq_mask_q[port_sel] <= pwdata[7:0];
                    default: ;
                endcase
            end else if (paddr == `PP_ADDR_SLEW) begin
                slew_q <= pwdata[7:0];
            end else if (paddr == `PP_ADDR_ROUTE) begin
                alt_route_select_q <= pwdata[3:0];
            end
        end
    end

    // write-one-to-clear mask for the flag register
    always_comb begin
        flag_clr = '0;
        if (wr_en && pstrb[0] && !is_global && reg_sel == `PP_OFS_FLAG) begin
            flag_clr[port_sel*8 +: 8] = pwdata[7:0];
        end
    end

    // sticky flags; a new edge wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_irq_flag_q <= '0;
        end else if (clk_en) begin
            pin_irq_flag_q <= (pin_irq_flag_q & ~flag_clr) | valid_edge;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    // read data is captured in the setup cycle and shown in the access cycle
    always_comb begin
        rd_d = 32'h00000000;
        if (!is_global) begin
            case (reg_sel)
                `PP_OFS_DATA: rd_d[7:0] = (direction_bits_q[port_sel] &
                    port_output_value_q[port_sel]) |
                    (~direction_bits_q[port_sel] & pin_sync_q[port_sel*8 +: 8]);
                `PP_OFS_INPUT: rd_d[7:0] = pin_sync_q[port_sel*8 +: 8];
                `PP_OFS_DIR: rd_d[7:0] = direction_bits_q[port_sel];
                `PP_OFS_OPEN_DRAIN: rd_d[7:0] = open_drain_select_q[port_sel];
                `PP_OFS_POLARITY: rd_d[7:0] = pull_polarity_select_q[port_sel];
                `PP_OFS_MASK: rd_d[7:0] = pin_irq_mask_q[port_sel];
                `PP_OFS_FLAG: rd_d[7:0] = pin_irq_flag_q[port_sel];
                default: rd_d = 32'h00000000;
            endcase
        end else if (paddr == `PP_ADDR_SLEW) begin
            rd_d[7:0] = slew_q;
        end else if (paddr == `PP_ADDR_ROUTE) begin
            rd_d[3:0] = alt_route_select_q;
        end else if (paddr == `PP_ADDR_MODE) begin
            rd_d[`PP_MODE_BOOT_BIT] = boot_mode_input;
            rd_d[`PP_MODE_RC_BIT] = rc_osc_running;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_q <= 32'h00000000;
        end else if (clk_en && setup) begin
            prdata_q <= addr_ok ? rd_d : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge filters and their sampling clock

    // bus clock samples in run and wait, the local oscillator in stop
    assign sample_en = stop_mode ? rc_tick : 1'b1;
    assign osc_run = stop_mode &&
        |(settling & pin_irq_mask_q & ~pin_irq_flag_q);

    stop_rc_osc u_rc_osc (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .osc_run(osc_run),
        .rc_tick(rc_tick),
        .osc_active(rc_osc_running)
    );

    // filters watch the pad level whatever the pin direction
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_filter
            pin_edge_filter u_filter (
                .clk(clk),
                .sys_rst(sys_rst),
                .clk_en(clk_en),
                .sample_en(sample_en),
                .pin_level(pin_sync_q[gi]),
                .edge_rising(pull_polarity_select_q[gi / 8][gi % 8]),
                .valid_edge(valid_edge[gi]),
                .settling(settling[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // interrupt requests and wake-up

    // one request per port from any flagged and enabled pin
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            irq_d[p] = |(pin_irq_flag_q[p] & pin_irq_mask_q[p]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_irq <= 4'h0;
            wake_req <= 1'b0;
        end else if (clk_en) begin
            port_irq <= irq_d;
            wake_req <= (|irq_d) && (stop_mode || wait_mode);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    // pwm channel k lands on port 1 pin k, or port 2 pin k when rerouted
    always_comb begin
        periph_own = '0;
        periph_val = '0;
        for (int k = 0; k < 4; k++) begin
            if (pwm_en[k]) begin
                if (alt_route_select_q[k]) begin
                    periph_own[16 + k] = 1'b1;
                    periph_val[16 + k] = pwm_chan[k];
                end else begin
                    periph_own[8 + k] = 1'b1;
                    periph_val[8 + k] = pwm_chan[k];
                end
            end
        end
    end

    assign out_val = (periph_own & periph_val) | (~periph_own & port_output_value_q);
    assign drive_en = periph_own | direction_bits_q;

    // open-drain pins release the pad instead of driving high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_out <= 32'h00000000;
            pin_oe <= 32'h00000000;
        end else if (clk_en) begin
            pin_out <= out_val;
            pin_oe <= drive_en & ~(open_drain_select_q & out_val);
        end
    end

    // slew limiting is forced off while stopped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slew_control <= 8'h00;
        end else if (clk_en) begin
            slew_control <= stop_mode ? 8'h00 : slew_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_od_no_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(clk_en) |-> ((pin_oe & pin_out & $past(open_drain_select_q)) == 32'h00000000))
        else $error("open-drain pin driven high");

    a_mask_gates_irq: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(clk_en) && (($past(pin_irq_flag_q[0]) & $past(pin_irq_mask_q[0])) == 8'h00)
            |-> !port_irq[0])
        else $error("masked flag raised a port request");

    a_irq_any_pin: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && |(pin_irq_flag_q[1] & pin_irq_mask_q[1]) |=> port_irq[1])
        else $error("enabled flag gave no port request");

    a_flag_set: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && valid_edge[0] |=> pin_irq_flag_q[0][0])
        else $error("edge did not set its flag");

    a_flag_sticky: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && pin_irq_flag_q[1][2] && !flag_clr[10] |=> pin_irq_flag_q[1][2])
        else $error("flag dropped without a clear");

    a_flag_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && flag_clr[10] && !valid_edge[10] |=> !pin_irq_flag_q[1][2])
        else $error("write one did not clear flag");

    a_run_sampling: assert property (
        @(posedge clk) disable iff (sys_rst)
        !stop_mode |-> sample_en)
        else $error("filters idle outside stop mode");

    a_wake_mode: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(clk_en) && wake_req |-> port_irq != 4'h0 && $past(stop_mode || wait_mode))
        else $error("wake request without cause");

    a_route_alt: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && pwm_en[0] && alt_route_select_q[0] |=> pin_out[16] == $past(pwm_chan[0]))
        else $error("rerouted pwm channel not on alternate pin");

    a_boot_latch: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(sys_rst) && $past(clk_en) |-> boot_mode_input == $past(dbg_sync_q))
        else $error("boot mode not latched at reset release");

    a_slew_stop: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(stop_mode) |-> slew_control == 8'h00)
        else $error("slew limiting left on in stop");
endmodule

// ===== hw/port_pin_map.svh
// register offsets, reset values and timing counts of the pin port block
`ifndef PORT_PIN_MAP_SVH
`define PORT_PIN_MAP_SVH

// per-port register offsets inside a 32-byte port window
`define PP_OFS_DATA 3'h0
`define PP_OFS_INPUT 3'h1
`define PP_OFS_DIR 3'h2
`define PP_OFS_OPEN_DRAIN 3'h3
`define PP_OFS_POLARITY 3'h4
`define PP_OFS_MASK 3'h5
`define PP_OFS_FLAG 3'h6

// global register byte addresses
`define PP_ADDR_SLEW 12'h080
`define PP_ADDR_ROUTE 12'h084
`define PP_ADDR_MODE 12'h088

// field positions
`define PP_MODE_BOOT_BIT 0
`define PP_MODE_RC_BIT 1

// reset values
`define PP_RST_BYTE 8'h00
`define PP_RST_ROUTE 4'h0

// filter: consecutive samples per level and saturation of the run counter
`define PP_FILTER_RUN 3'h4
`define PP_FILTER_SAT 3'h7

// stop-mode sampling oscillator: bus clocks per sample tick
`define PP_RC_DIV 4'h4

`endif

// ===== hw/port_pin_pkg.sv
// types shared by the pin port block
package port_pin_pkg;
    typedef enum logic [0:0] {
        FILT_WAIT_IDLE = 1'b0,
        FILT_ARMED = 1'b1
    } filt_state_type;
    typedef logic [31:0] pin_vec_type;
    typedef logic [7:0] byte_type;
endpackage

// ===== hw/stop_rc_osc.sv
// gated sampling oscillator used by the filters in stop mode
`timescale 1ns/1ps
`include "port_pin_map.svh"
module stop_rc_osc (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic osc_run,
    output logic rc_tick,
    output logic osc_active
);
    logic [3:0] div_q;

    // divider runs only while some pin still needs samples
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= 4'h0;
            osc_active <= 1'b0;
        end else if (clk_en) begin
            osc_active <= osc_run;
            if (!osc_run || div_q == `PP_RC_DIV - 4'h1) begin
                div_q <= 4'h0;
            end else begin
                div_q <= div_q + 4'h1;
            end
        end
    end

    assign rc_tick = osc_active && osc_run && div_q == `PP_RC_DIV - 4'h1;

    a_rc_gated: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(clk_en) && !$past(osc_run) |-> !osc_active && !rc_tick)
        else $error("stop oscillator running without demand");
endmodule
